// ==== vemc_cfg_regs.v ====
// Purpose: product data window, indirect config access and message capability
// Assumes: one config access at a time, held only for the cfgReq cycle
// Notes: all state freezes while ce is low
// Notes on behaviour
// R1: the data window holds the EEPROM word found at the VPD address plus 40h.
// R2: byte 0 of the data window is the byte at the VPD address, higher bytes follow it.
// R3: reads and writes of the data window move only the bytes whose enables are set.
// R4: the index register keeps an 8-bit and a 4-bit index, zero after reset, rest read zero.
// R5: each access to the indirect window goes to the internal register chosen by the index.
// R6: the lowest byte of the capability header reads 05h.
// R7: the next-link byte of the capability reads 00h, ending the chain.
// R8: enable clear passes INTx pins through, enable set uses messages and ignores the pins.
// R9: the requested message count is read-only and reads 000.
// R10: software programs the allocated count with codes 000 to 101 only; it resets to 000.
// R11: the VPD flag starts reads when written 0 and writes when written 1; the sequencer ends them. Here vpdOpFlag is an unused input.
// R12: with messages on, an event becomes a memory write of the payload to the 64-bit address.
// R13: bits 1:0 of the lower message address read as zero.
`timescale 1ns/1ns
`default_nettype none
`include "vemc_map.vh"
module vemc_cfg_regs (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire cfgReq,
    input wire cfgWr,
    input wire [7:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWdata,
    output reg [31:0] cfgRdata,
    output reg cfgAck,
    input wire [5:0] vpdDwordAddr,
    input wire vpdOpFlag,
    output reg [8:0] eepromByteAddr,
    output wire [31:0] eepromWdata,
    input wire eepromRdDone,
    input wire [31:0] eepromRdata,
    output wire [11:0] extIdx,
    output reg extRdReq,
    output reg extWrReq,
    output reg [31:0] extWdata,
    output reg [3:0] extByteEn,
    input wire [31:0] extRdata,
    input wire extAck,
    input wire [3:0] intxPin,
    output reg [3:0] intxOut,
    input wire msgEvent,
    output wire msiEnable,
    output wire memWrValid,
    input wire memWrReady,
    output wire [63:0] memWrAddr,
    output wire [15:0] memWrData
);

localparam ST_IDLE = 1'b0;
localparam ST_EXT = 1'b1;

reg state_q;
reg [31:0] productData_q;
reg [`VEMC_IDX_MSB:0] index_q;
reg msgEnable_q;
reg [2:0] allocCount_q;
reg [31:2] addrLo_q;
reg [31:0] addrHi_q;
reg [15:0] payload_q;
reg [3:0] intxSync1_q;
reg [3:0] intxSync2_q;
reg [31:0] readVal;
reg extIsWr_q;
wire [31:0] addrLoMerged;
wire [31:0] ctrlWord;
wire [31:0] addrLoWord;
wire hostWr;
wire msgFire;

////////////////////////////////////////////////////////////////////////////////
// helpers

// replace only the enabled bytes of a word
function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] be;
    integer i;
    begin
        mergeBytes = oldVal;
        for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
                mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
    end
endfunction

// keep only the enabled bytes of a word, others zero
function [31:0] maskBytes;
    input [31:0] val;
    input [3:0] be;
    begin
        maskBytes = mergeBytes(`VEMC_ZERO32, val, be);
    end
endfunction

// dword register hit
function hitReg;
    input [7:0] addr;
    input [7:0] offset;
    begin
        hitReg = (addr[7:2] == offset[7:2]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// assembled read words

// capability header, next link and control in one dword
assign ctrlWord = {8'h00,
                   `VEMC_WIDE_CAPABLE,
                   allocCount_q,
                   `VEMC_REQ_COUNT, // read-only count [R9]
                   msgEnable_q,
                   `VEMC_CAP_NEXT, // end of chain [R7]
                   `VEMC_CAP_ID}; // capability identifier [R6]

assign addrLoWord = {addrLo_q, `VEMC_ADDR_LO_ALIGN}; // dword aligned [R13]

// low address merged with a write, alignment bits dropped when stored
assign addrLoMerged = mergeBytes(addrLoWord, cfgWdata, cfgByteEn);

// outputs taken straight from registers
assign extIdx = index_q; // index drives the internal selection [R5]
assign eepromWdata = productData_q; // byte 0 is the byte at the VPD address [R2]
assign msiEnable = msgEnable_q;
assign hostWr = (state_q == ST_IDLE) && cfgReq && cfgWr;

// read multiplexer, unmapped offsets read zero
always @* begin
    readVal = `VEMC_ZERO32;
    if (hitReg(cfgAddr, `VEMC_OFF_PRODUCT_DATA)) begin
        readVal = maskBytes(productData_q, cfgByteEn); // enabled bytes only [R3]
    end else if (hitReg(cfgAddr, `VEMC_OFF_IND_INDEX)) begin
        readVal = {20'h0_0000, index_q}; // upper bits read zero [R4]
    end else if (hitReg(cfgAddr, `VEMC_OFF_MSG_CTRL)) begin
        readVal = ctrlWord;
    end else if (hitReg(cfgAddr, `VEMC_OFF_MSG_ADDR_LO)) begin
        readVal = addrLoWord;
    end else if (hitReg(cfgAddr, `VEMC_OFF_MSG_ADDR_HI)) begin
        readVal = addrHi_q;
    end else if (hitReg(cfgAddr, `VEMC_OFF_MSG_PAYLOAD)) begin
        readVal = {16'h0000, payload_q};
    end
end

////////////////////////////////////////////////////////////////////////////////
// access sequencer: local registers answer next cycle, window waits for extAck
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_q <= ST_IDLE;
        cfgAck <= 1'b0;
        cfgRdata <= `VEMC_ZERO32;
        extRdReq <= 1'b0;
        extWrReq <= 1'b0;
        extWdata <= `VEMC_ZERO32;
        extByteEn <= 4'h0;
        extIsWr_q <= 1'b0;
    end else if (ce) begin
        cfgAck <= 1'b0;
        extRdReq <= 1'b0;
        extWrReq <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (cfgReq && hitReg(cfgAddr, `VEMC_OFF_IND_WINDOW)) begin
                    // forward the access to the indexed register [R5]
                    extRdReq <= !cfgWr;
                    extWrReq <= cfgWr;
                    extWdata <= cfgWdata;
                    extByteEn <= cfgByteEn;
                    extIsWr_q <= cfgWr; // request pulse is gone by the answer
                    state_q <= ST_EXT;
                end else if (cfgReq) begin
                    // local register, answered next cycle
                    cfgAck <= 1'b1;
                    cfgRdata <= cfgWr ? `VEMC_ZERO32 : readVal;
                end
            end
            ST_EXT: begin
                // window answer one cycle after extAck, writes read zero
                if (extAck) begin
                    cfgAck <= 1'b1;
                    cfgRdata <= extIsWr_q ? `VEMC_ZERO32 : extRdata; // [R5]
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// product data window and EEPROM address
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        productData_q <= `VEMC_PRODUCT_RESET;
        eepromByteAddr <= `VEMC_PRODUCT_BASE;
    end else if (ce) begin
        // EEPROM word sits 40h above the VPD address [R1]
        eepromByteAddr <= {1'b0, vpdDwordAddr, 2'b00} + `VEMC_PRODUCT_BASE;
        if (eepromRdDone) begin
            // finished read loads the data window; no VPD flag is kept here [R11]
            productData_q <= eepromRdata; // [R1]
        end else if (hostWr && hitReg(cfgAddr, `VEMC_OFF_PRODUCT_DATA)) begin
            productData_q <= mergeBytes(productData_q, cfgWdata, cfgByteEn); // [R3]
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// indirect index register
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        index_q <= `VEMC_IDX_RESET; // [R4]
    end else if (ce) begin
        if (hostWr && hitReg(cfgAddr, `VEMC_OFF_IND_INDEX)) begin
            if (cfgByteEn[0]) begin
                index_q[7:0] <= cfgWdata[7:0]; // register number [R4]
            end
            if (cfgByteEn[1]) begin
                index_q[11:8] <= cfgWdata[11:8]; // extended number [R4]
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// message capability registers
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        msgEnable_q <= 1'b0; // [R8]
        allocCount_q <= `VEMC_ALLOC_RESET; // [R10]
        addrLo_q <= `VEMC_ADDR_LO_RESET;
        addrHi_q <= `VEMC_ADDR_RESET;
        payload_q <= `VEMC_PAYLOAD_RESET;
    end else if (ce) begin
        // enable and allocated count share byte lane 2
        if (hostWr && hitReg(cfgAddr, `VEMC_OFF_MSG_CTRL) && cfgByteEn[2]) begin
            msgEnable_q <= cfgWdata[`VEMC_CTL_EN_BIT];
            allocCount_q <= cfgWdata[`VEMC_CTL_ALLOC_MSB:`VEMC_CTL_ALLOC_LSB];
        end
        if (hostWr && hitReg(cfgAddr, `VEMC_OFF_MSG_ADDR_LO)) begin
            addrLo_q <= addrLoMerged[31:2]; // [R13]
        end
        if (hostWr && hitReg(cfgAddr, `VEMC_OFF_MSG_ADDR_HI)) begin
            addrHi_q <= mergeBytes(addrHi_q, cfgWdata, cfgByteEn);
        end
        // payload keeps the low half, upper half reads zero
        if (hostWr && hitReg(cfgAddr, `VEMC_OFF_MSG_PAYLOAD)) begin
            if (cfgByteEn[0]) begin
                payload_q[7:0] <= cfgWdata[7:0];
            end
            if (cfgByteEn[1]) begin
                payload_q[15:8] <= cfgWdata[15:8];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// legacy pin path, synchronised then gated by the enable
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        intxSync1_q <= 4'h0;
        intxSync2_q <= 4'h0;
        intxOut <= 4'h0;
    end else if (ce) begin
        // two flops before any logic reads the pins
        intxSync1_q <= intxPin;
        intxSync2_q <= intxSync1_q;
        intxOut <= msgEnable_q ? 4'h0 : intxSync2_q; // pins ignored in message mode [R8]
    end
end

// message events only while messages are enabled
assign msgFire = msgEnable_q && msgEvent; // [R8]

////////////////////////////////////////////////////////////////////////////////
// message write issuer
vemc_msg_writer vemc_msg_writer_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .fire(msgFire), // [R12]
    .addrIn({addrHi_q, addrLoWord}),
    .dataIn(payload_q),
    .memWrValid(memWrValid),
    .memWrReady(memWrReady),
    .memWrAddr(memWrAddr),
    .memWrData(memWrData)
);

endmodule
`default_nettype wire

// ==== vemc_map.vh ====
// Purpose: register offsets, field positions and reset values of the block
// Assumes: byte addresses within configuration space, 32-bit registers
// Notes: definitions only
`ifndef VEMC_MAP_VH
`define VEMC_MAP_VH

// register byte offsets
`define VEMC_OFF_PRODUCT_DATA 8'hDC
`define VEMC_OFF_IND_INDEX 8'hE0
`define VEMC_OFF_IND_WINDOW 8'hE4
`define VEMC_OFF_MSG_CTRL 8'hF0
`define VEMC_OFF_MSG_ADDR_LO 8'hF4
`define VEMC_OFF_MSG_ADDR_HI 8'hF8
`define VEMC_OFF_MSG_PAYLOAD 8'hFC

// product data window
`define VEMC_PRODUCT_BASE 9'h040
`define VEMC_PRODUCT_RESET 32'h0000_0000

// indirect index fields
`define VEMC_IDX_W 12
`define VEMC_IDX_MSB 11
`define VEMC_IDX_RESET 12'h000

// capability header and control fields
`define VEMC_CAP_ID 8'h05
`define VEMC_CAP_NEXT 8'h00
`define VEMC_CTL_EN_BIT 16
`define VEMC_CTL_REQ_LSB 17
`define VEMC_CTL_REQ_MSB 19
`define VEMC_CTL_ALLOC_LSB 20
`define VEMC_CTL_ALLOC_MSB 22
`define VEMC_CTL_WIDE_BIT 23
`define VEMC_REQ_COUNT 3'h0
`define VEMC_ALLOC_RESET 3'h0
`define VEMC_WIDE_CAPABLE 1'h1

// message address and data
`define VEMC_ADDR_RESET 32'h0000_0000
`define VEMC_ADDR_LO_RESET 30'h0000_0000
`define VEMC_ADDR_LO_ALIGN 2'h0
`define VEMC_PAYLOAD_RESET 16'h0000
`define VEMC_ZERO32 32'h0000_0000

`endif

// ==== vemc_msg_writer.v ====
// Purpose: issues one memory write per interrupt message event, except events lost to an already pending one
// Assumes: fire is a one-cycle pulse on clk, ready may stall any time
// Notes: one event is remembered while a write is outstanding
`timescale 1ns/1ns
`default_nettype none
`include "vemc_map.vh"
module vemc_msg_writer (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire fire,
    input wire [63:0] addrIn,
    input wire [15:0] dataIn,
    output reg memWrValid,
    input wire memWrReady,
    output reg [63:0] memWrAddr,
    output reg [15:0] memWrData
);

localparam ST_IDLE = 1'b0;
localparam ST_SEND = 1'b1;

reg state_q;
reg pend_q;

////////////////////////////////////////////////////////////////////////////////
// pending event and write launch
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_q <= ST_IDLE;
        pend_q <= 1'b0;
        memWrValid <= 1'b0;
        memWrAddr <= {`VEMC_ADDR_RESET, `VEMC_ADDR_RESET};
        memWrData <= `VEMC_PAYLOAD_RESET;
    end else if (ce) begin
        case (state_q)
            ST_IDLE: begin
                if (pend_q || fire) begin
                    // payload written to the 64-bit target [R12]
                    memWrValid <= 1'b1;
                    memWrAddr <= addrIn;
                    memWrData <= dataIn;
                    state_q <= ST_SEND;
                    pend_q <= 1'b0;
                end
            end
            ST_SEND: begin
                if (fire) begin
                    pend_q <= 1'b1; // event during a write is remembered; one arriving in a pend_q launch cycle is lost
                end
                if (memWrReady) begin
                    memWrValid <= 1'b0;
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
                memWrValid <= 1'b0;
            end
        endcase
    end
end

endmodule
`default_nettype wire

// ==== vemc_README_none.v ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== vemc_cfg_regs_chk.sv ====
// Purpose: port-level assertions for vemc_cfg_regs
// Assumes: one clock, rstn asynchronous active low, one config access in flight
// Notes: helper flops follow the pending window access and the last taken address
`timescale 1ns/1ns
`default_nettype none
module vemc_cfg_regs_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic cfgReq,
    input wire logic cfgWr,
    input wire logic [7:0] cfgAddr,
    input wire logic [31:0] cfgRdata,
    input wire logic cfgAck,
    input wire logic [5:0] vpdDwordAddr,
    input wire logic [8:0] eepromByteAddr,
    input wire logic extRdReq,
    input wire logic extWrReq,
    input wire logic extAck,
    input wire logic [3:0] intxPin,
    input wire logic [3:0] intxOut,
    input wire logic msgEvent,
    input wire logic msiEnable,
    input wire logic memWrValid,
    input wire logic memWrReady,
    input wire logic [63:0] memWrAddr,
    input wire logic [15:0] memWrData
);
    logic winBusy_q, lastWr_q, takeNow, capRd;
    logic [7:0] lastAddr_q;
    assign takeNow = cfgReq && ce && !winBusy_q;
    assign capRd = cfgAck && !lastWr_q && lastAddr_q[7:2] == 6'h3C;

    // track taken access and pending window access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            winBusy_q <= 1'h0;
            lastWr_q <= 1'h0;
            lastAddr_q <= 8'h00;
        end else if (takeNow) begin
            winBusy_q <= cfgAddr[7:2] == 6'h39;
            lastWr_q <= cfgWr;
            lastAddr_q <= cfgAddr;
        end else if (cfgAck) begin
            winBusy_q <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_WIN_REQ: assert property (takeNow && cfgAddr[7:2] == 6'h39 |=>
        extWrReq == lastWr_q && extRdReq == !lastWr_q) else $error("window request wrong");
    AST_WIN_ANSWER: assert property (winBusy_q && extAck |=> cfgAck)
        else $error("window answer missing");
    AST_CAP_ID: assert property (capRd |-> cfgRdata[7:0] == 8'h05)
        else $error("capability id wrong");
    AST_REQ_CNT: assert property (capRd |-> cfgRdata[19:17] == 3'h0)
        else $error("requested count wrong");
    AST_ADDR_ALIGN: assert property (cfgAck && lastAddr_q[7:2] == 6'h3D |->
        cfgRdata[1:0] == 2'h0) else $error("message address not aligned");
    AST_VPD_ADDR: assert property ($past(ce) |->
        eepromByteAddr == {$past(vpdDwordAddr), 2'h0} + 9'h040) else $error("eeprom address");
    AST_INTX_PASS: assert property ((ce && !msiEnable && $stable(intxPin))[*4] |->
        intxOut == intxPin) else $error("legacy pins not passed");
    AST_INTX_MUTE: assert property (msiEnable && $past(msiEnable) |-> intxOut == 4'h0)
        else $error("legacy pins not ignored");
    AST_MSG_LAUNCH: assert property (msgEvent && msiEnable && !memWrValid |=> memWrValid)
        else $error("message write not launched");
    AST_MSG_HOLD: assert property (memWrValid && !memWrReady |=> memWrValid &&
        $stable(memWrAddr) && $stable(memWrData)) else $error("message write not held");

    // main scenarios
    cover property (winBusy_q && extAck);
    cover property (memWrValid && !memWrReady);
    cover property (capRd && cfgRdata[16]);
endmodule
bind vemc_cfg_regs vemc_cfg_regs_chk vemc_cfg_regs_chk_i (.*);
`default_nettype wire

// ==== vemc_far_model.sv ====
// Purpose: internal register space and message write sink beside vemc_cfg_regs
// Assumes: requests are one-cycle pulses, answer three cycles later
// Notes: sink stalls each message write two cycles before ready
`timescale 1ns/1ns
`default_nettype none
module vemc_far_model (
    input wire logic clk,
    input wire logic extRdReq,
    input wire logic extWrReq,
    input wire logic [11:0] extIdx,
    input wire logic [31:0] extWdata,
    input wire logic [3:0] extByteEn,
    output logic [31:0] extRdata,
    output logic extAck,
    input wire logic memWrValid,
    output logic memWrReady
);
    logic [31:0] regs [0:4095];
    logic [31:0] laneMask;
    logic [1:0] dly = 2'h0;
    logic [1:0] stall = 2'h0;
    assign laneMask = {{8{extByteEn[3]}}, {8{extByteEn[2]}}, {8{extByteEn[1]}}, {8{extByteEn[0]}}};
    initial begin
        extAck = 1'h0;
        extRdata = 32'h0000_0000;
        memWrReady = 1'h0;
        for (int k = 0; k < 4096; k++) regs[k] = 32'h0000_0000;
    end

    // indexed register space, byte-lane writes, delayed answer
    always @(posedge clk) begin
        if (extRdReq || extWrReq) begin
            dly <= 2'h2;
        end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
        end
        if (extWrReq) begin
            regs[extIdx] <= (regs[extIdx] & ~laneMask) | (extWdata & laneMask);
        end
        extAck <= dly == 2'h1;
        extRdata <= dly == 2'h1 ? regs[extIdx] : ~extRdata;
    end

    // message sink, ready after two stalled cycles
    always @(posedge clk) begin
        stall <= (!memWrValid || memWrReady) ? 2'h0 : stall + 2'h1;
        memWrReady <= memWrValid && !memWrReady && stall == 2'h1;
    end
endmodule
`default_nettype wire

// ==== test_vemc_cfg_regs.sv ====
// Purpose: register-level tests of vemc_cfg_regs through config accesses
// Assumes: inputs change at the falling edge, checks sampled there
// Notes: far model supplies internal registers and the message sink
`timescale 1ns/1ns
`default_nettype none
module test_vemc_cfg_regs;
    logic clk = 0, rstn = 0, ce = 1, cfgReq = 0, cfgWr = 0, vpdOpFlag = 0, eepromRdDone = 0;
    logic msgEvent = 0, cfgAck, extRdReq, extWrReq, extAck, msiEnable, memWrValid, memWrReady;
    logic [7:0] cfgAddr = 8'h00;
    logic [3:0] cfgByteEn = 4'h0, intxPin = 4'h0, extByteEn, intxOut;
    logic [31:0] cfgWdata = 32'h0000_0000, eepromRdata = 32'h0000_0000, rd;
    logic [31:0] cfgRdata, eepromWdata, extWdata, extRdata;
    logic [5:0] vpdDwordAddr = 6'h00;
    logic [8:0] eepromByteAddr;
    logic [11:0] extIdx;
    logic [63:0] memWrAddr, lastAddr;
    logic [15:0] memWrData, lastData;
    int error_cnt = 0, check_count = 0, wrCnt = 0;

    vemc_cfg_regs vemc_cfg_regs_i (.*);
    vemc_far_model vemc_far_model_i (.*);

    always #10 clk = ~clk;

    // record accepted message writes
    always @(posedge clk) begin
        if (memWrValid && memWrReady) begin
            wrCnt++;
            lastAddr = memWrAddr;
            lastData = memWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one config access, waits for its ack
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        int n;
        @(negedge clk);
        cfgReq = 1;
        cfgWr = wr;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWdata = d;
        @(negedge clk);
        cfgReq = 0;
        for (n = 0; cfgAck !== 1'h1 && n < 20; n++) @(negedge clk);
        if (n == 20) chk(1'h0, 1'h1);
        rd = cfgRdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e);
        cfg(0, a, be, 32'h0000_0000);
        chk(rd, e);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard
    initial begin
        #80000;
        error_cnt++;
        report_and_stop;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1;
        rdchk(8'hF0, 4'hF, 32'h0080_0005);
        rdchk(8'hE0, 4'hF, 32'h0000_0000);
        rdchk(8'hDC, 4'hF, 32'h0000_0000);
        rdchk(8'hE8, 4'hF, 32'h0000_0000);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            cfg(1, 8'hF0, 4'h4, {8'hFF, 1'h1, i[2:0], 4'hF, 16'hFFFF});
            rdchk(8'hF0, 4'hF, {8'h00, 1'h1, i[2:0], 4'h1, 16'h0005});
        end
        chk(msiEnable, 1'h1);
        $display("test message_control done");
        cfg(1, 8'hF4, 4'hF, 32'hFFFF_FFFF);
        rdchk(8'hF4, 4'hF, 32'hFFFF_FFFC);
        cfg(1, 8'hF8, 4'hF, 32'h1234_5678);
        cfg(1, 8'hFC, 4'hF, 32'hFFFF_ABCD);
        rdchk(8'hFC, 4'hF, 32'h0000_ABCD);
        msgEvent = 1;
        repeat (2) @(negedge clk);
        msgEvent = 0;
        intxPin = 4'hA;
        repeat (20) @(negedge clk);
        chk(wrCnt, 2);
        chk(lastAddr, 64'h1234_5678_FFFF_FFFC);
        chk(lastData, 16'hABCD);
        chk(intxOut, 4'h0);
        cfg(1, 8'hF0, 4'h4, 32'h0000_0000);
        msgEvent = 1;
        @(negedge clk);
        msgEvent = 0;
        repeat (20) @(negedge clk);
        chk(wrCnt, 2);
        chk(intxOut, 4'hA);
        ce = 0;
        intxPin = 4'h5;
        repeat (6) @(negedge clk);
        chk(intxOut, 4'hA);
        ce = 1;
        repeat (6) @(negedge clk);
        chk(intxOut, 4'h5);
        $display("test message_write done");
        cfg(1, 8'hE0, 4'hF, 32'hFFFF_FFFF);
        rdchk(8'hE0, 4'hF, 32'h0000_0FFF);
        chk(extIdx, 12'hFFF);
        cfg(1, 8'hE4, 4'hF, 32'hCAFE_F00D);
        chk(rd, 32'h0000_0000);
        rdchk(8'hE4, 4'hF, 32'hCAFE_F00D);
        chk(vemc_far_model_i.regs[12'hFFF], 32'hCAFE_F00D);
        cfg(1, 8'hE0, 4'h1, 32'h0000_0000);
        cfg(1, 8'hE4, 4'h2, 32'h1111_1111);
        rdchk(8'hE4, 4'hF, 32'h0000_1100);
        $display("test indirect_window done");
        vpdDwordAddr = 6'h3F;
        repeat (2) @(negedge clk);
        chk(eepromByteAddr, 9'h13C);
        eepromRdata = 32'h4433_2211;
        eepromRdDone = 1;
        @(negedge clk);
        eepromRdDone = 0;
        eepromRdata = 32'hBBCC_DDEE;
        rdchk(8'hDC, 4'hF, 32'h4433_2211);
        rdchk(8'hDC, 4'h5, 32'h0033_0011);
        cfg(1, 8'hDC, 4'h2, 32'hAAAA_AAAA);
        chk(eepromWdata, 32'h4433_AA11);
        $display("test product_data done");
        report_and_stop;
    end
endmodule
`default_nettype wire
